// File: common/acm_params.svh
// Constants for the converter control block: field positions, widths, timing.
// Assumes inclusion by the package, the design files, the checker and the bench, nothing else.
`ifndef ACM_PARAMS_SVH
`define ACM_PARAMS_SVH
`define ACM_CHAN_W 5
`define ACM_MODE_W 4
`define ACM_DIV_W 8
`define ACM_STC_W 8
`define ACM_RES_W 12
`define ACM_CNT_W 10
`define ACM_MODE_RES_HI 1
`define ACM_MODE_RES_LO 0
`define ACM_MODE_NOPWRDN_BIT 2
`define ACM_MODE_NOCAL_BIT 3
`define ACM_RES_CODE_10 2'h0
`define ACM_RES_CODE_12 2'h1
`define ACM_RES_CODE_8 2'h2
`define ACM_BITS_8 10'h008
`define ACM_BITS_10 10'h00A
`define ACM_BITS_12 10'h00C
`define ACM_CLK_DIV_MULT 10'h004
`define ACM_SAMPLE_BASE 10'h002
`define ACM_CAL_CYCLES 10'h002
`define ACM_CHAN_SUPPLY 5'h00
`define ACM_CHAN_INT_TEMP 5'h1F
`define ACM_QUAD_COUNT 4'hA
`define ACM_ANALOG_W 32
`endif

// File: common/acm_pkg.sv
// Types shared by the converter control block files.
// Assumes acm_params.svh is found on the include path.
`include "acm_params.svh"
package acm_pkg;
  typedef logic [`ACM_CHAN_W-1:0] acm_chan_type;
  typedef logic [`ACM_MODE_W-1:0] acm_mode_type;
  typedef logic [`ACM_DIV_W-1:0] acm_div_type;
  typedef logic [`ACM_STC_W-1:0] acm_stc_type;
  typedef logic [`ACM_RES_W-1:0] acm_result_type;
  typedef enum logic [2:0] {ACM_IDLE, ACM_SAMPLE, ACM_DISTRIB, ACM_CAL, ACM_DONE} acm_state_type;
endpackage

// File: hw/acm_clk_div.sv
// Converter-clock enable generator: counts system clocks and pulses once per period.
// Assumes the divider value comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "acm_params.svh"
module acm_clk_div (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Divider control
  input wire acm_pkg::acm_div_type clock_divider_control_i,
  input wire logic restart_i,
  // Converter clock enable, kept internal
  output logic converter_clock_en_o
);
  import acm_pkg::*;
  logic [`ACM_CNT_W:0] cnt_r;
  logic [`ACM_CNT_W:0] cnt_nxt;
  logic [`ACM_CNT_W:0] last;
  acm_div_type div_seen_r;
  logic en_r;
  logic en_nxt;

  // Period is four times one plus the divider, counted in system clocks.
  assign last = `ACM_CLK_DIV_MULT * ({3'h0, clock_divider_control_i} + 11'h001) - 11'h001; // R15

  always_comb begin
    cnt_nxt = cnt_r + 11'h001;
    en_nxt = 1'b0;
    if (restart_i || (div_seen_r != clock_divider_control_i)) begin
      cnt_nxt = '0; // R25
    end else if (cnt_r >= last) begin
      cnt_nxt = '0;
      en_nxt = 1'b1; // R15
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
      en_r <= 1'b0;
      div_seen_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      en_r <= en_nxt;
      div_seen_r <= clock_divider_control_i;
    end
  end

  assign converter_clock_en_o = en_r;
endmodule
`default_nettype wire

// File: hw/acm_ctrl.sv
// Converter control: channel decode, mode, reference, clock divider and sequencing.
// Assumes control inputs arrive from fabric logic, possibly unrelated timing.
// Summary of operation
// R1: Five-bit value n selects channel n.
// R2: Thirty-two channels; thirty user, two internal.
// R3: Channel 0 converts internal core supply.
// R4: Channel 31 converts internal temperature diode.
// R5: Quad k on channels 3k+1..3k+3.
// R6: Internal channels fixed regardless of quads.
// R7: Caller strobes internal temperature diode itself.
// R8: Power-down input gates only comparators.
// R9: Mode low bits: 10, 12, 8 bit.
// R10: 8-bit result upper bits, low four zero.
// R11: 10-bit result upper bits, low two zero.
// R12: Mode bit 3 low adds two-cycle calibration.
// R13: Mode bit 2 low powers down after conversion.
// R14: Reference select: internal driven out, or external.
// R15: Converter period four times one plus divider.
// R16: Caller keeps converter clock 0.5 to 10 MHz.
// R17: Converter clock never leaves the block.
// R18: All control inputs synchronized to system clock.
// R19: Start strobe captured on rising clock edge.
// R20: Start strobe lasts exactly one clock.
// R21: Sample, busy, result-valid sequencing with result.
// R22: Sample phase lasts two plus sample-time cycles.
// R23: Distribution takes one cycle per result bit.
// R24: Settings captured at start, held through conversion.
// R25: Divider counter restarts when divider changes.
`timescale 1ns/10ps
`default_nettype none
`include "acm_params.svh"
module acm_ctrl (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Control inputs from fabric
  input wire logic conversion_start_strobe_i,
  input wire acm_pkg::acm_chan_type channel_select_i,
  input wire acm_pkg::acm_mode_type conversion_mode_config_i,
  input wire logic reference_source_sel_i,
  input wire acm_pkg::acm_div_type clock_divider_control_i,
  input wire acm_pkg::acm_stc_type sample_time_control_i,
  input wire logic comparator_power_down_i,
  input wire logic internal_temp_strobe_i,
  // Comparator data bit from the analog array, one per distribution cycle
  input wire logic comparator_bit_i,
  // Status to fabric
  output logic sample_o,
  output logic busy_o,
  output logic result_valid_o,
  output acm_pkg::acm_result_type result_o,
  // Analog front-end controls
  output logic [`ACM_ANALOG_W-1:0] mux_select_onehot_o,
  output logic supply_monitor_sel_o,
  output logic int_temp_diode_sel_o,
  output logic [`ACM_QUAD_COUNT-1:0] quad_voltage_input_sel_o,
  output logic [`ACM_QUAD_COUNT-1:0] quad_current_input_sel_o,
  output logic [`ACM_QUAD_COUNT-1:0] quad_temperature_input_sel_o,
  output logic int_temp_strobe_o,
  output logic comparator_enable_o,
  output logic converter_powered_o,
  output logic calibrating_o,
  output logic internal_ref_drive_o,
  output logic external_ref_sel_o
);
  import acm_pkg::*;

  // ----------------------------------------
  // Input synchronizers
  // ----------------------------------------
  // Fabric inputs are treated as asynchronous, so each goes through two flops.
  localparam int SYNC_W = 1 + `ACM_CHAN_W + `ACM_MODE_W + 1 + `ACM_DIV_W + `ACM_STC_W + 1 + 1 + 1;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic start_s;
  logic start_d_r;
  acm_chan_type chan_s;
  acm_mode_type mode_s;
  logic ref_s;
  acm_div_type div_s;
  acm_stc_type stc_s;
  logic pwrdn_s;
  logic tstrb_s;
  logic cbit_s;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      start_d_r <= 1'b0;
    end else begin
      sync1_r <= {conversion_start_strobe_i, channel_select_i, conversion_mode_config_i,
                  reference_source_sel_i, clock_divider_control_i, sample_time_control_i,
                  comparator_power_down_i, internal_temp_strobe_i, comparator_bit_i}; // R18
      sync2_r <= sync1_r; // R18
      start_d_r <= start_s;
    end
  end

  assign {start_s, chan_s, mode_s, ref_s, div_s, stc_s, pwrdn_s, tstrb_s, cbit_s} = sync2_r;

  // A one-clock strobe becomes one rising edge; a held-high strobe starts only once.
  logic start_evt;
  assign start_evt = start_s && !start_d_r; // R19 R20

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  acm_state_type state_r, state_nxt;
  acm_chan_type chan_r, chan_nxt;
  acm_mode_type mode_r, mode_nxt;
  logic ref_r, ref_nxt;
  acm_div_type div_r, div_nxt;
  acm_stc_type stc_r, stc_nxt;
  logic [`ACM_CNT_W-1:0] cnt_r, cnt_nxt;
  acm_result_type shift_r, shift_nxt;
  acm_result_type result_r, result_nxt;
  logic valid_r, valid_nxt;
  logic powered_r, powered_nxt;
  logic [`ACM_CNT_W-1:0] nbits;
  logic [`ACM_CNT_W-1:0] sample_len;
  logic cclk_en;
  logic [1:0] res_code;

  acm_clk_div u_clk_div (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .clock_divider_control_i(div_nxt),
    .restart_i(start_evt),
    .converter_clock_en_o(cclk_en)
  ); // R17

  assign res_code = mode_r[`ACM_MODE_RES_HI:`ACM_MODE_RES_LO];

  always_comb begin
    unique case (res_code) // R9
      `ACM_RES_CODE_12: nbits = `ACM_BITS_12;
      `ACM_RES_CODE_8: nbits = `ACM_BITS_8;
      default: nbits = `ACM_BITS_10;
    endcase
  end

  assign sample_len = `ACM_SAMPLE_BASE + {2'h0, stc_r}; // R22

  always_comb begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    mode_nxt = mode_r;
    ref_nxt = ref_r;
    div_nxt = div_r;
    stc_nxt = stc_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    result_nxt = result_r;
    valid_nxt = valid_r;
    powered_nxt = powered_r;
    if (start_evt) begin
      // A new start drops any conversion in flight.
      state_nxt = ACM_SAMPLE; // R21
      chan_nxt = chan_s; // R24
      mode_nxt = mode_s; // R24
      ref_nxt = ref_s; // R24
      div_nxt = div_s; // R24
      stc_nxt = stc_s;
      cnt_nxt = '0;
      shift_nxt = '0;
      valid_nxt = 1'b0; // R21
      powered_nxt = 1'b1;
    end else if (cclk_en) begin
      unique case (state_r)
        ACM_IDLE, ACM_DONE: begin
          state_nxt = state_r;
        end
        ACM_SAMPLE: begin
          if (cnt_r + 10'h001 >= sample_len) begin
            state_nxt = ACM_DISTRIB; // R22
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + 10'h001;
          end
        end
        ACM_DISTRIB: begin
          shift_nxt = {shift_r[`ACM_RES_W-2:0], cbit_s};
          if (cnt_r + 10'h001 >= nbits) begin // R23
            cnt_nxt = '0;
            state_nxt = mode_r[`ACM_MODE_NOCAL_BIT] ? ACM_DONE : ACM_CAL; // R12
          end else begin
            cnt_nxt = cnt_r + 10'h001;
          end
        end
        ACM_CAL: begin
          if (cnt_r + 10'h001 >= `ACM_CAL_CYCLES) begin // R12
            cnt_nxt = '0;
            state_nxt = ACM_DONE;
          end else begin
            cnt_nxt = cnt_r + 10'h001;
          end
        end
        default: begin
          state_nxt = ACM_IDLE;
        end
      endcase
    end
    // Result alignment and completion happen the cycle the last phase ends.
    if (!start_evt && cclk_en && state_r != ACM_DONE && state_nxt == ACM_DONE) begin
      unique case (res_code)
        `ACM_RES_CODE_8: result_nxt = {shift_nxt[7:0], 4'h0}; // R10
        `ACM_RES_CODE_12: result_nxt = shift_nxt;
        default: result_nxt = {shift_nxt[9:0], 2'h0}; // R11
      endcase
      valid_nxt = 1'b1; // R21
      powered_nxt = mode_r[`ACM_MODE_NOPWRDN_BIT]; // R13
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ACM_IDLE;
      chan_r <= '0;
      mode_r <= '0;
      ref_r <= 1'b0;
      div_r <= '0;
      stc_r <= '0;
      cnt_r <= '0;
      shift_r <= '0;
      result_r <= '0;
      valid_r <= 1'b0;
      powered_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      mode_r <= mode_nxt;
      ref_r <= ref_nxt;
      div_r <= div_nxt;
      stc_r <= stc_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      result_r <= result_nxt;
      valid_r <= valid_nxt;
      powered_r <= powered_nxt;
    end
  end

  // ----------------------------------------
  // Channel decode and analog controls
  // ----------------------------------------
  logic [`ACM_ANALOG_W-1:0] onehot_nxt;
  logic [`ACM_QUAD_COUNT-1:0] qv_nxt, qc_nxt, qt_nxt;
  logic [`ACM_ANALOG_W-1:0] onehot_r;
  logic [`ACM_QUAD_COUNT-1:0] qv_r, qc_r, qt_r;
  logic sample_r, busy_r, sup_r, itemp_r, tstrb_r, comp_en_r, cal_r, iref_r, eref_r;

  genvar gi;
  generate
    for (gi = 0; gi < `ACM_ANALOG_W; gi = gi + 1) begin : g_chan
      assign onehot_nxt[gi] = (chan_r == acm_chan_type'(gi)); // R1 R2
    end
    for (gi = 0; gi < `ACM_QUAD_COUNT; gi = gi + 1) begin : g_quad
      assign qv_nxt[gi] = onehot_nxt[3*gi+1]; // R5
      assign qc_nxt[gi] = onehot_nxt[3*gi+2]; // R5
      assign qt_nxt[gi] = onehot_nxt[3*gi+3]; // R5
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      onehot_r <= '0;
      qv_r <= '0;
      qc_r <= '0;
      qt_r <= '0;
      sample_r <= 1'b0;
      busy_r <= 1'b0;
      sup_r <= 1'b0;
      itemp_r <= 1'b0;
      tstrb_r <= 1'b0;
      comp_en_r <= 1'b0;
      cal_r <= 1'b0;
      iref_r <= 1'b0;
      eref_r <= 1'b0;
    end else begin
      onehot_r <= onehot_nxt;
      qv_r <= qv_nxt;
      qc_r <= qc_nxt;
      qt_r <= qt_nxt;
      sample_r <= (state_nxt == ACM_SAMPLE); // R21
      busy_r <= (state_nxt == ACM_SAMPLE) || (state_nxt == ACM_DISTRIB) ||
                (state_nxt == ACM_CAL); // R21
      sup_r <= (chan_r == `ACM_CHAN_SUPPLY); // R3 R6
      itemp_r <= (chan_r == `ACM_CHAN_INT_TEMP); // R4 R6
      tstrb_r <= tstrb_s; // R7
      comp_en_r <= powered_nxt && !pwrdn_s; // R8
      cal_r <= (state_nxt == ACM_CAL);
      iref_r <= !ref_r; // R14
      eref_r <= ref_r; // R14
    end
  end

  assign sample_o = sample_r;
  assign busy_o = busy_r;
  assign result_valid_o = valid_r;
  assign result_o = result_r;
  assign mux_select_onehot_o = onehot_r;
  assign supply_monitor_sel_o = sup_r;
  assign int_temp_diode_sel_o = itemp_r;
  assign quad_voltage_input_sel_o = qv_r;
  assign quad_current_input_sel_o = qc_r;
  assign quad_temperature_input_sel_o = qt_r;
  assign int_temp_strobe_o = tstrb_r;
  assign comparator_enable_o = comp_en_r;
  assign converter_powered_o = powered_r;
  assign calibrating_o = cal_r;
  assign internal_ref_drive_o = iref_r;
  assign external_ref_sel_o = eref_r;
endmodule
`default_nettype wire

// File: testbench/acm_ctrl_chk.sv
// Port-level checks for the converter control block.
// Assumes binding to acm_ctrl; names match its ports.
`timescale 1ns/10ps
`default_nettype none
`include "acm_params.svh"
module acm_ctrl_chk (
  // Clock, reset and inputs
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic conversion_start_strobe_i,
  input wire logic comparator_power_down_i,
  // Status
  input wire logic sample_o,
  input wire logic busy_o,
  input wire logic result_valid_o,
  input wire acm_pkg::acm_result_type result_o,
  // Front-end controls
  input wire logic [`ACM_ANALOG_W-1:0] mux_select_onehot_o,
  input wire logic supply_monitor_sel_o,
  input wire logic int_temp_diode_sel_o,
  input wire logic [`ACM_QUAD_COUNT-1:0] quad_voltage_input_sel_o,
  input wire logic [`ACM_QUAD_COUNT-1:0] quad_current_input_sel_o,
  input wire logic [`ACM_QUAD_COUNT-1:0] quad_temperature_input_sel_o,
  input wire logic comparator_enable_o,
  input wire logic internal_ref_drive_o,
  input wire logic external_ref_sel_o
);
  import acm_pkg::*;
  // ----
  // Checks
  // ----
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_start;
    $rose(conversion_start_strobe_i);
  endsequence
  sequence s_begin;
    ##3 (sample_o && busy_o && !result_valid_o);
  endsequence
  a_start_resp: assert property (s_start |-> s_begin)
    else $error("Late start response.");
  a_supply_map: assert property (supply_monitor_sel_o == mux_select_onehot_o[0])
    else $error("Supply select wrong.");
  a_temp_map: assert property (int_temp_diode_sel_o == mux_select_onehot_o[31])
    else $error("Diode select wrong.");
  a_onehot_sel: assert property (busy_o |-> $onehot(mux_select_onehot_o))
    else $error("Channel not one-hot.");
  for (genvar k = 0; k < `ACM_QUAD_COUNT; k++) begin : g_quad
    a_quad_map: assert property (mux_select_onehot_o[3*k+1 +: 3] ==
      {quad_temperature_input_sel_o[k], quad_current_input_sel_o[k], quad_voltage_input_sel_o[k]})
      else $error("Quad select wrong.");
  end
  a_ref_map: assert property ($past(rst_b_i) |->
    internal_ref_drive_o != external_ref_sel_o) else $error("Reference drive wrong.");
  a_done_valid: assert property ($fell(busy_o) |-> result_valid_o && !sample_o)
    else $error("No valid at completion.");
  a_result_hold: assert property (result_valid_o && $past(result_valid_o) |->
    $stable(result_o)) else $error("Result moved while valid.");
  a_pd_gate: assert property (comparator_power_down_i [*5] |-> !comparator_enable_o)
    else $error("Comparators left on.");
endmodule
bind acm_ctrl acm_ctrl_chk i_acm_ctrl_chk (.*);
`default_nettype wire

// File: testbench/acm_fab_model.sv
// Fabric-side model: drives the control inputs of the converter block.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/10ps
`default_nettype none
module acm_fab_model (
  // Clock
  input wire logic sys_clk_i,
  // Control outputs
  output var logic start_o,
  output var acm_pkg::acm_chan_type chan_o,
  output var acm_pkg::acm_mode_type mode_o,
  output var logic ref_o,
  output var acm_pkg::acm_div_type div_o,
  output var acm_pkg::acm_stc_type stc_o,
  output var logic pd_o,
  output var logic tstrobe_o,
  output var logic cbit_o
);
  import acm_pkg::*;
  // ----
  // Stimulus
  // ----
  initial begin
    {start_o, chan_o, mode_o, ref_o, div_o, stc_o, pd_o, tstrobe_o, cbit_o} = 30'h0;
  end
  // Settings go up a cycle before the strobe and stay until the next call.
  task automatic start_conv(input acm_chan_type ch, input acm_mode_type md, input logic rf,
      input acm_div_type dv, input acm_stc_type st, input logic b);
    @(negedge sys_clk_i);
    chan_o = ch;
    mode_o = (md[1:0] == 2'h3) ? {md[3:2], 2'h0} : md;
    ref_o = rf;
    // At 200 MHz only 4 to 99 keeps the converter clock in its range.
    div_o = (dv < 8'h04) ? 8'h04 : (dv > 8'h63) ? 8'h63 : dv;
    stc_o = st;
    cbit_o = b;
    @(negedge sys_clk_i);
    start_o = 1'b1;
    @(negedge sys_clk_i);
    start_o = 1'b0;
  endtask
  task automatic levels(input logic pd, input logic ts);
    @(negedge sys_clk_i);
    pd_o = pd;
    tstrobe_o = ts;
  endtask
  // Moves channel and divider mid-conversion; the block must keep what it captured.
  task automatic disturb(input acm_chan_type ch, input acm_div_type dv);
    @(negedge sys_clk_i);
    chan_o = ch;
    div_o = dv;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the converter control block.
// Assumes the fabric model and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "acm_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import acm_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic conversion_start_strobe_i, reference_source_sel_i, comparator_power_down_i;
  logic internal_temp_strobe_i, comparator_bit_i, sample_o, busy_o, result_valid_o;
  logic supply_monitor_sel_o, int_temp_diode_sel_o, int_temp_strobe_o, comparator_enable_o;
  logic converter_powered_o, calibrating_o, internal_ref_drive_o, external_ref_sel_o;
  acm_chan_type channel_select_i;
  acm_mode_type conversion_mode_config_i;
  acm_div_type clock_divider_control_i;
  acm_stc_type sample_time_control_i;
  acm_result_type result_o;
  logic [`ACM_ANALOG_W-1:0] mux_select_onehot_o;
  logic [`ACM_QUAD_COUNT-1:0] quad_voltage_input_sel_o, quad_current_input_sel_o;
  logic [`ACM_QUAD_COUNT-1:0] quad_temperature_input_sel_o;
  int err_count = 0;
  int tests_run = 0;
  // ----
  // Harness
  // ----
  always #2.5 sys_clk_i = ~sys_clk_i;
  acm_ctrl i_acm_ctrl (.*);
  acm_fab_model i_acm_fab_model (
    .sys_clk_i(sys_clk_i),
    .start_o(conversion_start_strobe_i),
    .chan_o(channel_select_i),
    .mode_o(conversion_mode_config_i),
    .ref_o(reference_source_sel_i),
    .div_o(clock_divider_control_i),
    .stc_o(sample_time_control_i),
    .pd_o(comparator_power_down_i),
    .tstrobe_o(internal_temp_strobe_i),
    .cbit_o(comparator_bit_i)
  );
  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d.", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // A constant comparator bit makes every result bit equal, so alignment shows plainly.
  task automatic conv(input acm_chan_type ch, input acm_mode_type md, input logic rf,
      input acm_div_type dv, input acm_stc_type st, input logic b, input acm_result_type ex,
      input logic inj);
    int p;
    int nb;
    int ns;
    int nw;
    int nc;
    p = 4 * (1 + dv);
    nb = (md[1:0] == 2'h1) ? 12 : (md[1:0] == 2'h2) ? 8 : 10;
    ns = 0;
    nw = 0;
    nc = 0;
    if (inj) begin
      i_acm_fab_model.start_conv(~ch, md, rf, dv + 8'h01, st, b);
      repeat (20) @(negedge sys_clk_i);
    end
    i_acm_fab_model.start_conv(ch, md, rf, dv, st, b);
    repeat (inj ? 2 : 3) @(negedge sys_clk_i);
    if (inj) begin
      i_acm_fab_model.disturb(~ch, dv + 8'h01);
    end
    `CHK("start", 1'b1, busy_o & sample_o & ~result_valid_o)
    while (busy_o === 1'b1 && nw < 3000) begin
      ns += (sample_o === 1'b1);
      nc += (calibrating_o === 1'b1);
      nw++;
      @(negedge sys_clk_i);
    end
    `CHK("sample length", (2 + st) * p, ns)
    `CHK("busy length", (2 + st + nb + (md[3] ? 0 : 2)) * p, nw)
    `CHK("calibration length", (md[3] ? 0 : 2) * p, nc)
    `CHK("valid", 1'b1, result_valid_o)
    `CHK("result", ex, result_o)
    `CHK("channel", 32'h1 << ch, mux_select_onehot_o)
    `CHK("reference", {~rf, rf}, {internal_ref_drive_o, external_ref_sel_o})
    `CHK("powered", md[2], converter_powered_o)
    $display("Conversion on channel %0d done.", ch);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    `CHK("idle", 1'b0, busy_o | sample_o | result_valid_o)
    `CHK("internal ref", 1'b1, internal_ref_drive_o)
    $display("Reset test done.");
    conv(5'h00, 4'h4, 1'b0, 8'h04, 8'h00, 1'b1, 12'hFFC, 1'b0);
    conv(5'h1F, 4'hA, 1'b1, 8'h05, 8'h03, 1'b1, 12'hFF0, 1'b0);
    conv(5'h04, 4'h1, 1'b0, 8'h04, 8'h01, 1'b1, 12'hFFF, 1'b0);
    conv(5'h1E, 4'hE, 1'b1, 8'h04, 8'h02, 1'b0, 12'h000, 1'b0);
    conv(5'h0D, 4'hD, 1'b0, 8'h06, 8'h00, 1'b0, 12'h000, 1'b1);
    `CHK("comparators on", 1'b1, comparator_enable_o)
    i_acm_fab_model.levels(1'b1, 1'b1);
    repeat (6) @(negedge sys_clk_i);
    `CHK("comparators off", 1'b0, comparator_enable_o)
    `CHK("still powered", 1'b1, converter_powered_o)
    `CHK("temp strobe", 1'b1, int_temp_strobe_o)
    $display("Power-down test done.");
    give_verdict();
  end
  // The tests need under 5000 clocks; four times that means a hang.
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
